// [core/irq_sleep_ctl.sv]
// Design decision made here: the APB register port.
`default_nettype none
// Behaviour
// - enable_b bit 3 gates brown-out interrupt
// - prio_lo_a holds seven source low bits
// - prio_hi_a holds matching high bits
// - brown-out low priority at prio_lo_b bit 4
// - brown-out high priority at prio_hi_b bit 4
// - priority registers reset zero; prio_lo_a bit-addressable
// - idle halts program counter, clocks run
// - serviced interrupt clears idle, resumes after
// - hardware reset restarts like power-on
// - idle drives strobes high
// - power-down drives strobes low
// - power-down stops clock, level ext only
// - power-down exits on ext level or reset
// - ext pin low restarts oscillator; low 1024 cycles arms wake
// - after pin high, run handler, resume
// - eight sources, four priority levels
module irq_sleep_ctl
    import irq_sleep_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] irq_req,
    input wire logic ext0_n_pin,
    input wire logic ext1_n_pin,
    input wire logic handler_return_instr,
    input wire logic bit_clr_lo_a,
    input wire logic [2:0] bit_sel,
    output logic irq_valid,
    output logic [2:0] irq_id,
    output logic [1:0] irq_level,
    output logic pc_halt,
    output logic osc_stop,
    output logic addr_latch_strobe,
    output logic prog_store_read_strobe,
    output logic irq_out
);
    // ********************
    // Pin synchronisers
    // ********************
    logic [1:0] ext_meta_r, ext_sync_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta_r <= 2'h3;
            ext_sync_r <= 2'h3;
        end else begin
            ext_meta_r <= {ext1_n_pin, ext0_n_pin};
            ext_sync_r <= ext_meta_r;
        end
    end

    // ********************
    // Registers
    // ********************
    logic [7:0] prio_hi_a_r, prio_lo_a_r, prio_hi_b_r, prio_lo_b_r;
    logic [7:0] enable_a_r, enable_b_r, power_ctl_r, evt_stat_r, evt_mask_r;
    logic [ADDR_W-1:0] idx;
    logic wr, rd, hit;
    logic [7:0] rd_byte;
    logic [7:0] evt_set;
    logic grant, in_service_clr;
    pm_state_t pm_r;
    assign idx = paddr[11:2];
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    always_comb begin
        hit = 1'b1;
        rd_byte = RESET_BYTE;
        unique case (idx)
            {2'h0, IDX_PRIO_HI_A}: rd_byte = prio_hi_a_r;
            {2'h0, IDX_PRIO_LO_A}: rd_byte = prio_lo_a_r;
            {2'h0, IDX_PRIO_HI_B}: rd_byte = prio_hi_b_r;
            {2'h0, IDX_PRIO_LO_B}: rd_byte = prio_lo_b_r;
            {2'h0, IDX_ENABLE_A}: rd_byte = enable_a_r;
            {2'h0, IDX_ENABLE_B}: rd_byte = enable_b_r;
            {2'h0, IDX_POWER_CTL}: rd_byte = power_ctl_r;
            {2'h0, IDX_EVT_STAT}: rd_byte = evt_stat_r;
            {2'h0, IDX_EVT_MASK}: rd_byte = evt_mask_r;
            default: hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !hit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end
    // Captured at setup so the word stands through the whole access phase

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_hi_a_r <= RESET_BYTE;
            prio_lo_a_r <= RESET_BYTE;
            prio_hi_b_r <= RESET_BYTE;
            prio_lo_b_r <= RESET_BYTE;
        end else begin
            if (wr && idx == {2'h0, IDX_PRIO_HI_A}) prio_hi_a_r <= pwdata[7:0] & SRC_MASK_A;
            if (wr && idx == {2'h0, IDX_PRIO_LO_A}) prio_lo_a_r <= pwdata[7:0] & SRC_MASK_A;
            else if (bit_clr_lo_a) prio_lo_a_r[bit_sel] <= 1'b0;
            if (wr && idx == {2'h0, IDX_PRIO_HI_B})
                prio_hi_b_r <= {3'h0, pwdata[BROWNOUT_PRIO_BIT], 4'h0};
            if (wr && idx == {2'h0, IDX_PRIO_LO_B})
                prio_lo_b_r <= {3'h0, pwdata[BROWNOUT_PRIO_BIT], 4'h0};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_a_r <= RESET_BYTE;
            enable_b_r <= RESET_BYTE;
            evt_mask_r <= RESET_BYTE;
        end else begin
            if (wr && idx == {2'h0, IDX_ENABLE_A}) enable_a_r <= pwdata[7:0];
            if (wr && idx == {2'h0, IDX_ENABLE_B})
                enable_b_r <= {4'h0, pwdata[BROWNOUT_EN_BIT], 3'h0};
            if (wr && idx == {2'h0, IDX_EVT_MASK}) evt_mask_r <= pwdata[7:0];
        end
    end

    // ********************
    // Arbitration
    // ********************
    logic [NUM_SRC-1:0] src_en;
    logic [1:0] lvl [NUM_SRC];
    logic [1:0] active_lvl_r;
    logic active_r;
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            if (g == BROWNOUT_SRC) begin : g_bo
                assign src_en[g] = irq_req[g] && enable_b_r[BROWNOUT_EN_BIT];
                assign lvl[g] = {prio_hi_b_r[BROWNOUT_PRIO_BIT], prio_lo_b_r[BROWNOUT_PRIO_BIT]};
            end else begin : g_std
                assign src_en[g] = irq_req[g] && enable_a_r[g];
                assign lvl[g] = {prio_hi_a_r[g], prio_lo_a_r[g]};
            end
        end
    endgenerate
    logic [2:0] best_id;
    logic [1:0] best_lvl;
    logic best_v;
    always_comb begin
        best_v = 1'b0;
        best_id = 3'h0;
        best_lvl = 2'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (src_en[i] && (!best_v || lvl[i] > best_lvl)) begin
                best_v = 1'b1;
                best_id = 3'(i);
                best_lvl = lvl[i];
            end
        end
    end
    assign grant = enable_a_r[EA_BIT] && best_v && (!active_r || best_lvl > active_lvl_r)
                   && pm_r != PM_DOWN;
    assign in_service_clr = handler_return_instr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_r <= 1'b0;
            active_lvl_r <= 2'h0;
            irq_valid <= 1'b0;
            irq_id <= 3'h0;
            irq_level <= 2'h0;
        end else begin
            irq_valid <= grant;
            if (grant) begin
                active_r <= 1'b1;
                active_lvl_r <= best_lvl;
                irq_id <= best_id;
                irq_level <= best_lvl;
            end else if (in_service_clr) begin
                active_r <= 1'b0;
            end
        end
    end

    // ********************
    // Power modes
    // ********************
    logic [10:0] hold_cnt_r;
    logic ext_low, ext_level_en, pd_wake;
    assign ext_low = (!ext_sync_r[0] && enable_a_r[EXT0_BIT])
                     || (!ext_sync_r[1] && enable_a_r[EXT1_BIT]);
    assign ext_level_en = enable_a_r[EA_BIT];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hold_cnt_r <= 11'h000;
        else if (pm_r != PM_DOWN || !ext_low) hold_cnt_r <= 11'h000;
        else if (hold_cnt_r < 11'(WAKE_HOLD_CYC)) hold_cnt_r <= hold_cnt_r + 11'h001;
    end
    assign pd_wake = pm_r == PM_DOWN && ext_level_en && !ext_low
                     && hold_cnt_r == 11'(WAKE_HOLD_CYC);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pm_r <= PM_RUN;
            power_ctl_r <= RESET_BYTE;
        end else begin
            unique case (pm_r)
                PM_RUN: begin
                    if (wr && idx == {2'h0, IDX_POWER_CTL}) begin
                        power_ctl_r <= pwdata[7:0];
                        if (pwdata[HALT_BIT]) pm_r <= PM_DOWN;
                        else if (pwdata[SLEEP_BIT]) pm_r <= PM_IDLE;
                    end
                end
                PM_IDLE: begin
                    if (grant) begin
                        power_ctl_r[SLEEP_BIT] <= 1'b0;
                        pm_r <= PM_RUN;
                    end
                end
                PM_DOWN: begin
                    if (pd_wake) begin
                        power_ctl_r[HALT_BIT] <= 1'b0;
                        pm_r <= PM_RUN;
                    end
                end
            endcase
        end
    end
    assign pc_halt = pm_r != PM_RUN;
    assign osc_stop = pm_r == PM_DOWN && !ext_low;
    assign addr_latch_strobe = pm_r == PM_IDLE;
    assign prog_store_read_strobe = pm_r == PM_IDLE;

    // ********************
    // Event interrupt
    // ********************
    always_comb begin
        evt_set = RESET_BYTE;
        evt_set[EV_IDLE_EXIT] = pm_r == PM_IDLE && grant;
        evt_set[EV_PD_EXIT] = pd_wake;
        evt_set[EV_GRANT] = grant;
    end
    // Set wins over the read-clear; only bits the read reported are cleared,
    // so an event landing during the setup cycle is not lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) evt_stat_r <= RESET_BYTE;
        else if (rd && idx == {2'h0, IDX_EVT_STAT}) begin
            evt_stat_r <= (evt_stat_r & ~prdata[7:0]) | evt_set;
        end else begin
            evt_stat_r <= evt_stat_r | evt_set;
        end
    end
    assign irq_out = |(evt_stat_r & evt_mask_r);

    // ********************
    // Checks
    // ********************
    property p_reset_zero;
        @(posedge pclk) $rose(presetn) |-> prio_hi_a_r == 8'h00 && prio_lo_b_r == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("prio not zero");
    property p_idle_strobe;
        @(posedge pclk) disable iff (!presetn)
            pm_r == PM_IDLE |-> addr_latch_strobe && prog_store_read_strobe;
    endproperty
    a_idle_strobe: assert property (p_idle_strobe) else $error("idle strobe");
    property p_down_strobe;
        @(posedge pclk) disable iff (!presetn)
            pm_r == PM_DOWN |-> !addr_latch_strobe && !prog_store_read_strobe && pc_halt;
    endproperty
    a_down_strobe: assert property (p_down_strobe) else $error("down strobe");
    property p_idle_exit;
        @(posedge pclk) disable iff (!presetn)
            pm_r == PM_IDLE && grant |=> pm_r == PM_RUN && !power_ctl_r[SLEEP_BIT];
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle exit");
    property p_down_stay;
        @(posedge pclk) disable iff (!presetn)
            pm_r == PM_DOWN && hold_cnt_r < 11'(WAKE_HOLD_CYC) |=> pm_r == PM_DOWN;
    endproperty
    a_down_stay: assert property (p_down_stay) else $error("early wake");
    property p_down_exit;
        @(posedge pclk) disable iff (!presetn) pd_wake |=> pm_r == PM_RUN;
    endproperty
    a_down_exit: assert property (p_down_exit) else $error("no wake");
    property p_bo_gate;
        @(posedge pclk) disable iff (!presetn)
            !enable_b_r[BROWNOUT_EN_BIT] |-> !src_en[BROWNOUT_SRC];
    endproperty
    a_bo_gate: assert property (p_bo_gate) else $error("brown-out ungated");
    property p_preempt;
        @(posedge pclk) disable iff (!presetn)
            active_r && grant |-> best_lvl > active_lvl_r;
    endproperty
    a_preempt: assert property (p_preempt) else $error("bad preempt");
    property p_grant_level;
        @(posedge pclk) disable iff (!presetn) grant |=> irq_valid && irq_level == $past(best_lvl);
    endproperty
    a_grant_level: assert property (p_grant_level) else $error("level lost");
    property p_idle_event;
        @(posedge pclk) disable iff (!presetn)
            pm_r == PM_IDLE && grant |=> evt_stat_r[EV_IDLE_EXIT];
    endproperty
    a_idle_event: assert property (p_idle_event) else $error("idle event lost");
    property p_idle_clock;
        @(posedge pclk) disable iff (!presetn)
            pm_r == PM_IDLE |-> pc_halt && !osc_stop;
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("idle clock");
    property p_lo_b_write;
        @(posedge pclk) disable iff (!presetn) wr && idx == {2'h0, IDX_PRIO_LO_B}
            |=> prio_lo_b_r[BROWNOUT_PRIO_BIT] == $past(pwdata[BROWNOUT_PRIO_BIT]);
    endproperty
    a_lo_b_write: assert property (p_lo_b_write) else $error("brown-out low bit");
    property p_bit_clr;
        @(posedge pclk) disable iff (!presetn) bit_clr_lo_a && !(wr && idx == {2'h0, IDX_PRIO_LO_A})
            |=> !prio_lo_a_r[$past(bit_sel)];
    endproperty
    a_bit_clr: assert property (p_bit_clr) else $error("bit clear lost");
    property p_down_level;
        @(posedge pclk) disable iff (!presetn)
            pm_r == PM_DOWN && ext_low |-> !osc_stop;
    endproperty
    a_down_level: assert property (p_down_level) else $error("osc not restarted");
    c_idle: cover property (@(posedge pclk) pm_r == PM_IDLE ##1 pm_r == PM_RUN);
    c_down: cover property (@(posedge pclk) pd_wake);
    c_nest: cover property (@(posedge pclk) active_r && grant);
    c_bo: cover property (@(posedge pclk) grant && best_id == 3'(BROWNOUT_SRC));
    c_wake_hold: cover property (@(posedge pclk) pm_r == PM_DOWN && ext_low);
endmodule
`default_nettype wire

// [pkg/irq_sleep_pkg.sv]
`default_nettype none
package irq_sleep_pkg;
    // Register indices; the bus byte address is four times the index
    localparam logic [7:0] IDX_PRIO_HI_A = 8'hB7;
    localparam logic [7:0] IDX_PRIO_LO_A = 8'hB8;
    localparam logic [7:0] IDX_PRIO_HI_B = 8'hF7;
    localparam logic [7:0] IDX_PRIO_LO_B = 8'hF8;
    localparam logic [7:0] IDX_ENABLE_B = 8'hE8;
    localparam logic [7:0] IDX_ENABLE_A = 8'hA8;
    localparam logic [7:0] IDX_POWER_CTL = 8'h87;
    localparam logic [7:0] IDX_EVT_STAT = 8'hC0;
    localparam logic [7:0] IDX_EVT_MASK = 8'hC1;
    localparam logic [7:0] IDX_SERVICE = 8'hC2;
    localparam int ADDR_W = 10;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] SRC_MASK_A = 8'h7F;
    localparam int BROWNOUT_EN_BIT = 3;
    localparam int BROWNOUT_PRIO_BIT = 4;
    localparam int EA_BIT = 7;
    localparam int SLEEP_BIT = 0;
    localparam int HALT_BIT = 1;
    localparam int EXT0_BIT = 0;
    localparam int EXT1_BIT = 2;
    localparam int NUM_SRC = 8;
    localparam int BROWNOUT_SRC = 7;
    localparam int WAKE_HOLD_CYC = 1024;
    // Event status bits
    localparam int EV_IDLE_EXIT = 0;
    localparam int EV_PD_EXIT = 1;
    localparam int EV_GRANT = 2;
    typedef enum logic [2:0] {
        PM_RUN = 3'b001,
        PM_IDLE = 3'b010,
        PM_DOWN = 3'b100
    } pm_state_t;
endpackage
`default_nettype wire

// [dv/irq_far_model.sv]
`default_nettype none
// ****************
// Far-side model
// ****************
module irq_far_model
    import irq_sleep_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_valid,
    input wire logic [7:0] svc_dly,
    input wire logic wake_go,
    output logic handler_return_instr,
    output logic ext0_n_pin,
    output logic ext1_n_pin
);
    int owed;
    int tmr;
    int hold;
    logic ret;
    assign ret = (tmr == 1);
    // Nested handlers: one return per grant, last granted ends first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            owed <= 0;
            tmr <= 0;
            handler_return_instr <= 1'b0;
        end else begin
            handler_return_instr <= ret;
            owed <= owed + int'(irq_valid) - int'(ret);
            if (ret) begin
                tmr <= 0;
            end else if (tmr == 0 && owed != 0) begin
                tmr <= int'(svc_dly);
            end else if (tmr > 1) begin
                tmr <= tmr - 1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= 0;
        end else if (wake_go) begin
            hold <= WAKE_HOLD_CYC + 4;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
    end
    // Pins have pull-ups, so a released pin reads high
    assign ext0_n_pin = (hold == 0);
    assign ext1_n_pin = 1'b1;
endmodule
`default_nettype wire

// [dv/test_irq_priority_and_sleep_modes.sv]
`default_nettype none
module test_irq_priority_and_sleep_modes
    import irq_sleep_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, handler_return_instr, ext0_n_pin, ext1_n_pin, irq_valid;
    logic pc_halt, osc_stop, addr_latch_strobe, prog_store_read_strobe, irq_out;
    logic [7:0] irq_req = 8'h00;
    logic bit_clr_lo_a = 1'b0;
    logic [2:0] bit_sel = 3'h0;
    logic [2:0] irq_id;
    logic [1:0] irq_level;
    logic [7:0] svc_dly = 8'h28;
    logic wake_go = 1'b0;
    logic [7:0] q;
    logic e;
    logic [5:0] g;
    int miscompares = 0;
    int cmp_count = 0;
    always #5 pclk = ~pclk;
    irq_sleep_ctl irq_sleep_ctl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .irq_req, .ext0_n_pin, .ext1_n_pin,
        .handler_return_instr, .bit_clr_lo_a, .bit_sel, .irq_valid, .irq_id, .irq_level,
        .pc_halt, .osc_stop, .addr_latch_strobe, .prog_store_read_strobe, .irq_out);
    irq_far_model irq_far_model_inst (.pclk, .presetn, .irq_valid, .svc_dly, .wake_go,
        .handler_return_instr, .ext0_n_pin, .ext1_n_pin);
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
        cmp_count++;
        if (s !== x) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", n, x, s);
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, input string n, input logic [7:0] x);
        apb(1'b0, i, 8'h00);
        chk(n, q, x);
    endtask
    task automatic gnt(input int lim);
        int k;
        k = 0;
        g = 6'h00;
        while (k < lim && g[5] !== 1'b1) begin
            @(posedge pclk);
            g = {irq_valid, irq_id, irq_level};
            k++;
        end
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        logic [7:0] ix [4] = '{IDX_PRIO_HI_A, IDX_PRIO_LO_A, IDX_PRIO_HI_B, IDX_PRIO_LO_B};
        logic [7:0] v [4] = '{8'h55, 8'h7F, 8'h10, 8'h10};
        for (int k = 0; k < 4; k++) rd(ix[k], "prio reset", 8'h00);
        // Unused bits are written as zero
        for (int k = 0; k < 4; k++) apb(1'b1, ix[k], v[k]);
        for (int k = 0; k < 4; k++) rd(ix[k], "prio rw", v[k]);
        apb(1'b1, IDX_ENABLE_B, 8'h08);
        rd(IDX_ENABLE_B, "enable_b", 8'h08);
        rd(8'h01, "unmapped", 8'h00);
        chk("slverr", 8'(e), 8'h01);
        bit_sel <= 3'h2;
        bit_clr_lo_a <= 1'b1;
        @(posedge pclk);
        bit_clr_lo_a <= 1'b0;
        rd(IDX_PRIO_LO_A, "bit clear", 8'h7B);
    endtask
    task automatic t_prio();
        apb(1'b1, IDX_ENABLE_A, 8'hFF);
        apb(1'b1, IDX_ENABLE_B, 8'h00);
        apb(1'b1, IDX_PRIO_HI_A, 8'h20);
        apb(1'b1, IDX_PRIO_LO_A, 8'h20);
        apb(1'b1, IDX_PRIO_HI_B, 8'h00);
        irq_req <= 8'h01;
        gnt(50);
        chk("grant lvl0", 8'(g), 8'h20);
        irq_req <= 8'h21;
        gnt(30);
        chk("preempt lvl3", 8'(g), 8'h37);
        irq_req <= 8'h80;
        gnt(150);
        chk("brownout off", 8'(g[5]), 8'h00);
        apb(1'b1, IDX_ENABLE_B, 8'h08);
        gnt(150);
        chk("brownout lvl1", 8'(g), 8'h3D);
        irq_req <= 8'h00;
        cyc(100);
        apb(1'b1, IDX_PRIO_LO_B, 8'h00);
        apb(1'b1, IDX_PRIO_HI_B, 8'h10);
        irq_req <= 8'h80;
        gnt(100);
        chk("brownout lvl2", 8'(g), 8'h3E);
        irq_req <= 8'h00;
        cyc(100);
    endtask
    task automatic t_idle();
        svc_dly <= 8'h03;
        apb(1'b1, IDX_EVT_MASK, 8'h01);
        apb(1'b1, IDX_POWER_CTL, 8'h01);
        cyc(2);
        chk("idle halt", 8'({pc_halt, osc_stop}), 8'h02);
        chk("idle strobes", 8'({addr_latch_strobe, prog_store_read_strobe}), 8'h03);
        irq_req <= 8'h02;
        gnt(50);
        chk("idle grant", 8'(g), 8'h24);
        cyc(2);
        chk("idle exit", 8'({pc_halt, irq_out}), 8'h01);
        irq_req <= 8'h00;
        rd(IDX_POWER_CTL, "idle bit", 8'h00);
        apb(1'b0, IDX_EVT_STAT, 8'h00);
        chk("idle event", q & 8'h01, 8'h01);
        cyc(1);
        chk("irq cleared", 8'(irq_out), 8'h00);
    endtask
    task automatic t_pdown();
        int k;
        apb(1'b1, IDX_POWER_CTL, 8'h02);
        cyc(2);
        chk("pd stop", 8'({pc_halt, osc_stop}), 8'h03);
        chk("pd strobes", 8'({addr_latch_strobe, prog_store_read_strobe}), 8'h00);
        irq_req <= 8'h02;
        cyc(20);
        chk("pd no wake", 8'(pc_halt), 8'h01);
        irq_req <= 8'h00;
        wake_go <= 1'b1;
        @(posedge pclk);
        wake_go <= 1'b0;
        cyc(10);
        chk("osc restart", 8'({pc_halt, osc_stop}), 8'h02);
        k = 0;
        while (pc_halt !== 1'b0 && k < 1300) begin
            @(posedge pclk);
            k++;
        end
        chk("pd exit time", 8'(k >= WAKE_HOLD_CYC - 12 && k < 1300), 8'h01);
        rd(IDX_POWER_CTL, "pd bit", 8'h00);
        apb(1'b0, IDX_EVT_STAT, 8'h00);
        chk("pd event", q & 8'h02, 8'h02);
    endtask
    task automatic t_rst();
        apb(1'b1, IDX_PRIO_LO_A, 8'h7F);
        apb(1'b1, IDX_POWER_CTL, 8'h01);
        cyc(2);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(1);
        chk("reset run", 8'(pc_halt), 8'h00);
        rd(IDX_PRIO_LO_A, "reset regs", 8'h00);
    endtask
    initial begin
        cyc(6);
        presetn <= 1'b1;
        t_regs();
        t_prio();
        t_idle();
        t_pdown();
        t_rst();
        conclude();
    end
    // Whole run is under 2200 cycles; this leaves wide margin
    initial begin
        #200us;
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
